// >>> fes_sequencer.v
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "fes_defs.vh"
module fes_sequencer #(
	parameter [31:0] ERASE_PULSE_CYC = `FES_T_SE_MIN_MS * 1000 * `FES_CLK_MHZ,
	parameter [31:0] ERASE_PULSE_MAX_CYC = `FES_T_SE_MAX_MS * 1000 * `FES_CLK_MHZ,
	parameter [31:0] PROG_LONG_CYC = `FES_T_SP_LONG_US * `FES_CLK_MHZ,
	parameter ADDR_W = 16
) (
	clock,
	arst_n,
	s_awaddr,
	s_awvalid,
	s_awready,
	s_wdata,
	s_wstrb,
	s_wvalid,
	s_wready,
	s_bresp,
	s_bvalid,
	s_bready,
	s_araddr,
	s_arvalid,
	s_arready,
	s_rdata,
	s_rresp,
	s_rvalid,
	s_rready,
	dev_reset_n,
	flash_write_enable_pin,
	software_write_enable,
	erase_setup,
	erase_pulse,
	erase_verify,
	program_setup,
	program_pulse,
	program_verify,
	mem_addr,
	mem_wdata,
	mem_wr,
	mem_rd,
	mem_rdata,
	watchdog_running,
	power_good
);
	input wire clock;
	input wire arst_n;
	input wire [7:0] s_awaddr;
	input wire s_awvalid;
	output wire s_awready;
	input wire [31:0] s_wdata;
	input wire [3:0] s_wstrb;
	input wire s_wvalid;
	output wire s_wready;
	output wire [1:0] s_bresp;
	output wire s_bvalid;
	input wire s_bready;
	input wire [7:0] s_araddr;
	input wire s_arvalid;
	output wire s_arready;
	output wire [31:0] s_rdata;
	output wire [1:0] s_rresp;
	output wire s_rvalid;
	input wire s_rready;
	output reg dev_reset_n;
	output reg flash_write_enable_pin;
	output reg software_write_enable;
	output reg erase_setup;
	output reg erase_pulse;
	output reg erase_verify;
	output reg program_setup;
	output reg program_pulse;
	output reg program_verify;
	output reg [ADDR_W-1:0] mem_addr;
	output reg [7:0] mem_wdata;
	output reg mem_wr;
	output reg mem_rd;
	input wire [7:0] mem_rdata;
	input wire watchdog_running;
	input wire power_good;

	// ----------------------------------------
	// Cycle counts
	// ----------------------------------------
	localparam [31:0] C_SSWE = `FES_T_SSWE_US * `FES_CLK_MHZ;
	localparam [31:0] C_SESU = `FES_T_SESU_US * `FES_CLK_MHZ;
	localparam [31:0] C_CE = `FES_T_CE_US * `FES_CLK_MHZ;
	localparam [31:0] C_CESU = `FES_T_CESU_US * `FES_CLK_MHZ;
	localparam [31:0] C_SEV = `FES_T_SEV_US * `FES_CLK_MHZ;
	localparam [31:0] C_SEVR = `FES_T_SEVR_US * `FES_CLK_MHZ;
	localparam [31:0] C_CEV = `FES_T_CEV_US * `FES_CLK_MHZ;
	localparam [31:0] C_CSWE = `FES_T_CSWE_US * `FES_CLK_MHZ;
	localparam [31:0] C_SP_SHORT = `FES_T_SP_SHORT_US * `FES_CLK_MHZ;
	localparam [31:0] C_SE = (ERASE_PULSE_CYC > ERASE_PULSE_MAX_CYC) ? ERASE_PULSE_MAX_CYC : ERASE_PULSE_CYC;
	localparam [31:0] C_RST_HOLD = `FES_RST_HOLD_CYC;
	localparam [31:0] C_RD_LAT = `FES_RD_LAT_CYC;
	localparam [9:0] ERASE_MAX = `FES_ERASE_MAX;
	localparam [9:0] PROG_SHORT = `FES_PROG_SHORT_MAX;
	localparam [9:0] PROG_MAX = `FES_PROG_SHORT_MAX + `FES_PROG_LONG_MAX;
	localparam [ADDR_W-1:0] UNIT = `FES_UNIT_BYTES;

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_FWE = 4'h1;
	localparam [3:0] S_SWE = 4'h2;
	localparam [3:0] S_PWR = 4'h3;
	localparam [3:0] S_SU = 4'h4;
	localparam [3:0] S_PULSE = 4'h5;
	localparam [3:0] S_PCLR = 4'h6;
	localparam [3:0] S_SUCLR = 4'h7;
	localparam [3:0] S_VSET = 4'h8;
	localparam [3:0] S_VDUM = 4'h9;
	localparam [3:0] S_VRD = 4'hA;
	localparam [3:0] S_VCHK = 4'hB;
	localparam [3:0] S_VCLR = 4'hC;
	localparam [3:0] S_SWECLR = 4'hD;
	localparam [3:0] S_WAIT = 4'hE;

	// ----------------------------------------
	// Bus slave and registers
	// ----------------------------------------
	wire wr_fire;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire rd_fire;
	wire [7:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_err;
	reg wr_err;

	reg boot_mode_q;
	reg [31:0] base_q;
	reg [31:0] len_q;
	reg [7:0] data_q;
	reg done_q;
	reg fail_q;

	function [31:0] fes_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] strb;
		integer i;
		begin
			fes_merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					fes_merge[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	fes_axil_slave u_slave (
		.clock(clock),
		.arst_n(arst_n),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_fire(rd_fire),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [7:0] rdata_m_q;
	reg [7:0] rdata_s_q;
	reg wdog_m_q;
	reg wdog_s_q;
	reg pwr_m_q;
	reg pwr_s_q;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_m_q <= 8'h00;
			rdata_s_q <= 8'h00;
			wdog_m_q <= 1'b0;
			wdog_s_q <= 1'b0;
			pwr_m_q <= 1'b0;
			pwr_s_q <= 1'b0;
		end else begin
			rdata_m_q <= mem_rdata;
			rdata_s_q <= rdata_m_q;
			wdog_m_q <= watchdog_running;
			wdog_s_q <= wdog_m_q;
			pwr_m_q <= power_good;
			pwr_s_q <= pwr_m_q;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	reg [3:0] state_q;
	reg [3:0] nxt_q;
	reg op_prog_q;
	reg fwe_tgt_q;
	reg [1:0] ph_q;
	reg [9:0] iter_q;
	reg [31:0] idx_q;
	reg all_ok_q;
	reg tmr_load;
	reg [31:0] tmr_count;
	wire tmr_done;
	wire busy = (state_q != S_IDLE);
	wire [7:0] expect_byte = op_prog_q ? data_q : `FES_VERIFY_FILL;
	wire [31:0] verify_len = op_prog_q ? {{(32-ADDR_W){1'b0}}, UNIT} : len_q;
	wire [9:0] iter_max = op_prog_q ? PROG_MAX : ERASE_MAX;
	wire start_cmd = wr_fire && (wr_addr == `FES_REG_CTRL) && wr_strb[0];

	fes_wait_timer u_timer (
		.clock(clock),
		.arst_n(arst_n),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	// Register writes and read decode
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			boot_mode_q <= 1'b0;
			base_q <= 32'h00000000;
			len_q <= 32'h00000001;
			data_q <= 8'h00;
		end else if (wr_fire && !busy) begin
			if (wr_addr == `FES_REG_CTRL) begin
				boot_mode_q <= wr_strb[0] ? wr_data[`FES_CTRL_BOOT] : boot_mode_q;
			end else if (wr_addr == `FES_REG_ADDR) begin
				base_q <= fes_merge(base_q, wr_data, wr_strb);
			end else if (wr_addr == `FES_REG_LEN) begin
				len_q <= fes_merge(len_q, wr_data, wr_strb);
			end else if (wr_addr == `FES_REG_DATA) begin
				data_q <= wr_strb[0] ? wr_data[7:0] : data_q;
			end
		end
	end

	always @* begin
		rd_err = 1'b0;
		rd_data = 32'h00000000;
		if (rd_addr == `FES_REG_CTRL) begin
			rd_data[`FES_CTRL_BOOT] = boot_mode_q;
		end else if (rd_addr == `FES_REG_ADDR) begin
			rd_data = base_q;
		end else if (rd_addr == `FES_REG_LEN) begin
			rd_data = len_q;
		end else if (rd_addr == `FES_REG_DATA) begin
			rd_data = {24'h0, data_q};
		end else if (rd_addr == `FES_REG_STAT) begin
			rd_data[`FES_STAT_BUSY] = busy;
			rd_data[`FES_STAT_DONE] = done_q;
			rd_data[`FES_STAT_FAIL] = fail_q;
			rd_data[`FES_STAT_WDOG] = (state_q == S_PULSE) && !wdog_s_q;
			rd_data[`FES_STAT_ITER_LSB +: 10] = iter_q;
		end else begin
			rd_err = 1'b1;
		end
	end

	always @* begin
		wr_err = 1'b0;
		if (wr_addr != `FES_REG_CTRL && wr_addr != `FES_REG_ADDR && wr_addr != `FES_REG_LEN
			&& wr_addr != `FES_REG_DATA && wr_addr != `FES_REG_STAT) begin
			wr_err = 1'b1;
		end
	end

	// Timer load is combinational so a wait starts in the cycle the step is taken
	always @* begin
		tmr_load = 1'b0;
		tmr_count = 32'h00000001;
		case (state_q)
			S_FWE: begin
				tmr_load = 1'b1;
				tmr_count = C_RST_HOLD;
			end
			S_SWE: begin
				tmr_load = 1'b1;
				tmr_count = C_SSWE;
			end
			S_SU: begin
				tmr_load = 1'b1;
				tmr_count = C_SESU;
			end
			S_PULSE: begin
				tmr_load = wdog_s_q;
				tmr_count = !op_prog_q ? C_SE : (iter_q < PROG_SHORT) ? C_SP_SHORT : PROG_LONG_CYC;
			end
			S_PCLR: begin
				tmr_load = 1'b1;
				tmr_count = C_CE;
			end
			S_SUCLR: begin
				tmr_load = 1'b1;
				tmr_count = C_CESU;
			end
			S_VSET: begin
				tmr_load = 1'b1;
				tmr_count = C_SEV;
			end
			S_VDUM: begin
				tmr_load = 1'b1;
				tmr_count = C_SEVR;
			end
			S_VRD: begin
				tmr_load = 1'b1;
				tmr_count = C_RD_LAT;
			end
			S_VCLR: begin
				tmr_load = 1'b1;
				tmr_count = C_CEV;
			end
			S_SWECLR: begin
				tmr_load = 1'b1;
				tmr_count = C_CSWE;
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			nxt_q <= S_IDLE;
			op_prog_q <= 1'b0;
			fwe_tgt_q <= 1'b0;
			ph_q <= 2'h0;
			iter_q <= 10'h000;
			idx_q <= 32'h00000000;
			all_ok_q <= 1'b1;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			dev_reset_n <= 1'b1;
			flash_write_enable_pin <= 1'b0;
			software_write_enable <= 1'b0;
			erase_setup <= 1'b0;
			erase_pulse <= 1'b0;
			erase_verify <= 1'b0;
			program_setup <= 1'b0;
			program_pulse <= 1'b0;
			program_verify <= 1'b0;
			mem_addr <= {ADDR_W{1'b0}};
			mem_wdata <= 8'h00;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
		end else if (!pwr_s_q) begin
			// Losing power drops everything at once; the part is protected, the operation failed
			state_q <= S_IDLE;
			fail_q <= busy | fail_q;
			dev_reset_n <= 1'b1;
			flash_write_enable_pin <= 1'b0;
			software_write_enable <= 1'b0;
			erase_setup <= 1'b0;
			erase_pulse <= 1'b0;
			erase_verify <= 1'b0;
			program_setup <= 1'b0;
			program_pulse <= 1'b0;
			program_verify <= 1'b0;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
		end else begin
			mem_wr <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (start_cmd && (wr_data[`FES_CTRL_ERASE] ^ wr_data[`FES_CTRL_PROG])) begin
						op_prog_q <= wr_data[`FES_CTRL_PROG];
						fwe_tgt_q <= 1'b1;
						ph_q <= 2'h0;
						iter_q <= 10'h000;
						done_q <= 1'b0;
						fail_q <= 1'b0;
						state_q <= S_FWE;
					end
				end
				S_FWE: begin
					// Phase 0 enters device reset in boot mode, 1 moves the pin, 2 releases reset
					if (ph_q == 2'h0) begin
						dev_reset_n <= !boot_mode_q;
					end else if (ph_q == 2'h1) begin
						flash_write_enable_pin <= fwe_tgt_q;
					end else begin
						dev_reset_n <= 1'b1;
					end
					ph_q <= ph_q + 2'h1;
					state_q <= S_WAIT;
					nxt_q <= (ph_q != 2'h2) ? S_FWE : (fwe_tgt_q ? S_SWE : S_IDLE);
					done_q <= (ph_q == 2'h2) && !fwe_tgt_q && !fail_q;
				end
				S_SWE: begin
					software_write_enable <= 1'b1;
					idx_q <= 32'h00000000;
					state_q <= S_WAIT;
					nxt_q <= op_prog_q ? S_PWR : S_SU;
				end
				S_PWR: begin
					// Load one unit of data before each program pulse
					if (idx_q == {{(32-ADDR_W){1'b0}}, UNIT}) begin
						state_q <= S_SU;
					end else begin
						mem_addr <= base_q[ADDR_W-1:0] + idx_q[ADDR_W-1:0];
						mem_wdata <= data_q;
						mem_wr <= 1'b1;
						idx_q <= idx_q + 32'h00000001;
					end
				end
				S_SU: begin
					program_setup <= op_prog_q;
					erase_setup <= !op_prog_q;
					state_q <= S_WAIT;
					nxt_q <= S_PULSE;
				end
				S_PULSE: begin
					// A runaway without a watchdog could hold the pulse forever, so hold off here
					if (wdog_s_q) begin
						program_pulse <= op_prog_q;
						erase_pulse <= !op_prog_q;
						state_q <= S_WAIT;
						nxt_q <= S_PCLR;
					end
				end
				S_PCLR: begin
					program_pulse <= 1'b0;
					erase_pulse <= 1'b0;
					state_q <= S_WAIT;
					nxt_q <= S_SUCLR;
				end
				S_SUCLR: begin
					program_setup <= 1'b0;
					erase_setup <= 1'b0;
					state_q <= S_WAIT;
					nxt_q <= S_VSET;
				end
				S_VSET: begin
					program_verify <= op_prog_q;
					erase_verify <= !op_prog_q;
					idx_q <= 32'h00000000;
					all_ok_q <= 1'b1;
					state_q <= S_WAIT;
					nxt_q <= S_VDUM;
				end
				S_VDUM: begin
					mem_addr <= base_q[ADDR_W-1:0] + idx_q[ADDR_W-1:0];
					mem_wdata <= `FES_VERIFY_FILL;
					mem_wr <= 1'b1;
					state_q <= S_WAIT;
					nxt_q <= S_VRD;
				end
				S_VRD: begin
					mem_rd <= 1'b1;
					state_q <= S_WAIT;
					nxt_q <= S_VCHK;
				end
				S_VCHK: begin
					mem_rd <= 1'b0;
					all_ok_q <= all_ok_q && (rdata_s_q == expect_byte);
					idx_q <= idx_q + 32'h00000001;
					state_q <= (idx_q + 32'h00000001 >= verify_len) ? S_VCLR : S_VDUM;
				end
				S_VCLR: begin
					program_verify <= 1'b0;
					erase_verify <= 1'b0;
					state_q <= S_WAIT;
					if (all_ok_q) begin
						nxt_q <= S_SWECLR;
					end else if (iter_q + 10'h001 >= iter_max) begin
						fail_q <= 1'b1;
						nxt_q <= S_SWECLR;
					end else begin
						iter_q <= iter_q + 10'h001;
						idx_q <= 32'h00000000;
						nxt_q <= op_prog_q ? S_PWR : S_SU;
					end
				end
				S_SWECLR: begin
					software_write_enable <= 1'b0;
					fwe_tgt_q <= 1'b0;
					ph_q <= 2'h0;
					state_q <= S_WAIT;
					nxt_q <= S_FWE;
				end
				S_WAIT: begin
					if (tmr_done) begin
						state_q <= nxt_q;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> fes_defs.vh
`ifndef FES_DEFS_VH
`define FES_DEFS_VH
// What this block does
// - Wait 1 us after write enable set.
// - Wait 100 us after erase setup set.
// - Erase pulse lasts 10 to 100 ms.
// - Wait 10 us after erase pulse clear.
// - Wait 10 us after erase setup clear.
// - Wait 20 us after verify set.
// - Dummy write all ones, wait 2 us.
// - Wait 4 us after verify clear.
// - Wait 100 us after write enable clear.
// - At most 100 erase iterations, else failure.
// - Program loop: 6 short, 994 long iterations.
// - Program 128-byte units, one pulse each.
// - Boot mode: change enable pin under reset, except on power loss, which drops it with reset released.
// - User mode: enable pin changes anytime.
// - Drop enable pin only with bits clear, except on power loss, which drops pin and bits in the same cycle.
// - Enable pin high only while programming/erasing.
// - Watchdog running before any pulse bit.
// - Enable pin low while power unstable.

// ----------------------------------------
// Timing
// ----------------------------------------
`define FES_CLK_MHZ 40
`define FES_T_SSWE_US 1
`define FES_T_SESU_US 100
`define FES_T_SE_MIN_MS 10
`define FES_T_SE_MAX_MS 100
`define FES_T_CE_US 10
`define FES_T_CESU_US 10
`define FES_T_SEV_US 20
`define FES_T_SEVR_US 2
`define FES_T_CEV_US 4
`define FES_T_CSWE_US 100
`define FES_T_SP_SHORT_US 30
`define FES_T_SP_LONG_US 200
`define FES_RST_HOLD_CYC 64
`define FES_RD_LAT_CYC 4

// ----------------------------------------
// Limits and patterns
// ----------------------------------------
`define FES_ERASE_MAX 100
`define FES_PROG_SHORT_MAX 6
`define FES_PROG_LONG_MAX 994
`define FES_UNIT_BYTES 128
`define FES_VERIFY_FILL 8'hFF

// ----------------------------------------
// Register map
// ----------------------------------------
`define FES_REG_CTRL 8'h00
`define FES_REG_ADDR 8'h04
`define FES_REG_LEN 8'h08
`define FES_REG_DATA 8'h0C
`define FES_REG_STAT 8'h10
`define FES_CTRL_ERASE 0
`define FES_CTRL_PROG 1
`define FES_CTRL_BOOT 2
`define FES_STAT_BUSY 0
`define FES_STAT_DONE 1
`define FES_STAT_FAIL 2
`define FES_STAT_WDOG 3
`define FES_STAT_ITER_LSB 16
`define FES_RESP_OKAY 2'b00
`define FES_RESP_SLVERR 2'b10
`endif

// >>> fes_wait_timer.v
`timescale 1ns/100ps
`include "fes_defs.vh"
module fes_wait_timer (
	clock,
	arst_n,
	load,
	count,
	done
);
	input wire clock;
	input wire arst_n;
	input wire load;
	input wire [31:0] count;
	output wire done;

	reg [31:0] cnt_q;
	reg busy_q;

	// Done fires exactly count cycles after load, and one cycle after load for a count of zero
	assign done = busy_q && (cnt_q == 32'h00000000);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 32'h00000000;
			busy_q <= 1'b0;
		end else if (load) begin
			cnt_q <= (count == 32'h00000000) ? 32'h00000000 : count - 32'h00000001;
			busy_q <= 1'b1;
		end else if (done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 32'h00000001;
		end
	end
endmodule

// >>> fes_axil_slave.v
`timescale 1ns/100ps
`include "fes_defs.vh"
module fes_axil_slave (
	clock,
	arst_n,
	s_awaddr,
	s_awvalid,
	s_awready,
	s_wdata,
	s_wstrb,
	s_wvalid,
	s_wready,
	s_bresp,
	s_bvalid,
	s_bready,
	s_araddr,
	s_arvalid,
	s_arready,
	s_rdata,
	s_rresp,
	s_rvalid,
	s_rready,
	wr_fire,
	wr_addr,
	wr_data,
	wr_strb,
	wr_err,
	rd_fire,
	rd_addr,
	rd_data,
	rd_err
);
	input wire clock;
	input wire arst_n;
	input wire [7:0] s_awaddr;
	input wire s_awvalid;
	output wire s_awready;
	input wire [31:0] s_wdata;
	input wire [3:0] s_wstrb;
	input wire s_wvalid;
	output wire s_wready;
	output reg [1:0] s_bresp;
	output reg s_bvalid;
	input wire s_bready;
	input wire [7:0] s_araddr;
	input wire s_arvalid;
	output wire s_arready;
	output reg [31:0] s_rdata;
	output reg [1:0] s_rresp;
	output reg s_rvalid;
	input wire s_rready;
	output wire wr_fire;
	output reg [7:0] wr_addr;
	output reg [31:0] wr_data;
	output reg [3:0] wr_strb;
	input wire wr_err;
	output wire rd_fire;
	output wire [7:0] rd_addr;
	input wire [31:0] rd_data;
	input wire rd_err;

	reg aw_got_q;
	reg w_got_q;

	// Address and data may arrive in either order; both are held until the response
	assign s_awready = !aw_got_q && !s_bvalid;
	assign s_wready = !w_got_q && !s_bvalid;
	assign wr_fire = aw_got_q && w_got_q && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign rd_fire = s_arvalid && s_arready;
	assign rd_addr = s_araddr;

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'b00;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h00000000;
			s_rresp <= 2'b00;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_got_q <= 1'b1;
				wr_addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_got_q <= 1'b1;
				wr_data <= s_wdata;
				wr_strb <= s_wstrb;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_err ? `FES_RESP_SLVERR : `FES_RESP_OKAY;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
			if (rd_fire) begin
				s_rvalid <= 1'b1;
				s_rdata <= rd_data;
				s_rresp <= rd_err ? `FES_RESP_SLVERR : `FES_RESP_OKAY;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> fes_monitor.sv
`timescale 1ns/100ps
module fes_monitor #(
	parameter [31:0] ERASE_PULSE_CYC = 32'h32,
	parameter [31:0] ERASE_PULSE_MAX_CYC = 32'h64,
	parameter [31:0] PROG_LONG_CYC = 32'h14
) (
	input logic clock,
	input logic arst_n,
	input logic dev_reset_n,
	input logic flash_write_enable_pin,
	input logic software_write_enable,
	input logic erase_setup,
	input logic erase_pulse,
	input logic erase_verify,
	input logic program_setup,
	input logic program_pulse,
	input logic program_verify,
	input logic [7:0] mem_wdata,
	input logic mem_wr,
	input logic mem_rd,
	input logic watchdog_running,
	input logic power_good
);
	// ----
	// Ages
	// ----
	// Ages saturate so a long idle never wraps into a short wait
	logic [6:0] v;
	logic [6:0] v_q;
	logic [31:0] age [7];
	logic [2:0] pg_n;
	logic [9:0] ep_n;
	logic [9:0] pp_n;
	logic [15:0] wr_n;
	wire ctl_any = software_write_enable | erase_setup | erase_pulse | erase_verify | program_setup | program_pulse
		| program_verify;
	assign v = {program_pulse, mem_wr, erase_verify, erase_pulse, erase_setup, software_write_enable,
		flash_write_enable_pin};
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			v_q <= '0;
			pg_n <= '0;
			ep_n <= '0;
			pp_n <= '0;
			wr_n <= '0;
			for (int i = 0; i < 7; i++) age[i] <= '1;
		end else begin
			v_q <= v;
			for (int i = 0; i < 7; i++) age[i] <= (v[i] != v_q[i]) ? 32'h1 : age[i] + {31'h0, age[i] != '1};
			pg_n <= !power_good ? 3'h0 : pg_n + {2'h0, pg_n != 3'h4};
			ep_n <= !software_write_enable ? 10'h0 : ep_n + {9'h0, erase_pulse & !v_q[3]};
			pp_n <= !software_write_enable ? 10'h0 : pp_n + {9'h0, program_pulse & !v_q[6]};
			wr_n <= (program_setup | program_verify | !software_write_enable) ? 16'h0 : wr_n + {15'h0, mem_wr};
		end
	end
	// ----
	// Checks
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n || pg_n != 3'h4);
	sequence s_pulse_end; $fell(erase_pulse); endsequence
	sequence s_dummy_wr; erase_verify && mem_wr; endsequence
	sequence s_pin_drop; $fell(flash_write_enable_pin); endsequence
	swe_setup_a: assert property ($rose(erase_setup) |-> software_write_enable && age[1] >= 32'h28)
		else $error("setup too soon");
	setup_pulse_a: assert property ($rose(erase_pulse) |-> erase_setup && age[2] >= 32'hFA0)
		else $error("pulse too soon");
	pulse_width_a: assert property (s_pulse_end |-> age[3] >= ERASE_PULSE_CYC && age[3] <= ERASE_PULSE_MAX_CYC)
		else $error("pulse width");
	pulse_unsetup_a: assert property ($fell(erase_setup) |-> age[3] >= 32'h190)
		else $error("setup cleared too soon");
	unsetup_verify_a: assert property ($rose(erase_verify) |-> !erase_setup && age[2] >= 32'h190)
		else $error("verify too soon");
	verify_dummy_a: assert property (s_dummy_wr |-> age[4] >= 32'h320 && mem_wdata == 8'hFF)
		else $error("dummy write");
	dummy_read_a: assert property ($rose(mem_rd) && erase_verify |-> age[5] >= 32'h4F)
		else $error("read too soon");
	verify_gap_a: assert property ($rose(erase_setup) || $fell(software_write_enable) |-> age[4] >= 32'hA0)
		else $error("verify gap");
	swe_pin_a: assert property (s_pin_drop |-> $past(ctl_any) == 1'h0 && age[1] >= 32'hFA0)
		else $error("pin dropped early");
	erase_limit_a: assert property ($rose(erase_pulse) |-> ep_n < 10'h64)
		else $error("erase count");
	prog_phase_a: assert property ($fell(program_pulse) |->
		age[6] >= (pp_n <= 10'h6 ? 32'h4B0 : PROG_LONG_CYC) && pp_n <= 10'h3E8)
		else $error("program pulse");
	unit_load_a: assert property ($rose(program_setup) |-> wr_n == 16'h80)
		else $error("unit size");
	boot_hold_a: assert property ($rose(dev_reset_n) |-> age[0] >= 32'h40)
		else $error("pin outside reset");
	pin_gate_a: assert property (ctl_any |-> flash_write_enable_pin)
		else $error("bits without pin");
	wdog_first_a: assert property ($rose(erase_pulse) || $rose(program_pulse) |-> $past(watchdog_running, 3))
		else $error("pulse without watchdog");
	power_off_a: assert property (@(posedge clock) disable iff (!arst_n)
		!$past(power_good, 4) && !power_good |-> !flash_write_enable_pin)
		else $error("pin high without power");
endmodule
bind fes_sequencer fes_monitor #(.ERASE_PULSE_CYC(ERASE_PULSE_CYC), .ERASE_PULSE_MAX_CYC(ERASE_PULSE_MAX_CYC),
	.PROG_LONG_CYC(PROG_LONG_CYC)) u_mon (.*);

// >>> fes_flash_model.sv
`timescale 1ns/100ps
module fes_flash_model (
	input logic clock,
	input logic flash_write_enable_pin,
	input logic software_write_enable,
	input logic erase_setup,
	input logic erase_pulse,
	input logic erase_verify,
	input logic program_verify,
	input logic [15:0] mem_addr,
	input logic [7:0] mem_wdata,
	input logic mem_wr,
	input logic mem_rd,
	input logic [7:0] fail_first,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last;
	logic ep_q;
	logic swe_q;
	int skip;
	initial begin
		last = '0;
		for (int i = 0; i < 65536; i++) mem[i] = '0;
	end
	// Unselected lines show the inverse of the last byte, never a stale copy
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
	always @(posedge clock) begin
		ep_q <= erase_pulse;
		swe_q <= software_write_enable;
		if (software_write_enable && !swe_q) skip = fail_first;
		if (mem_rd) last <= mem[mem_addr];
		// Verify dummy writes must not land in the array
		if (mem_wr && flash_write_enable_pin && software_write_enable && !erase_verify && !program_verify) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (!erase_pulse && ep_q && erase_setup && flash_write_enable_pin) begin
			if (skip > 0) skip--;
			else for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
		end
	end
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
	logic clock, arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, watchdog_running, power_good;
	logic [7:0] s_awaddr, s_araddr, fail_first;
	logic [31:0] s_wdata, d;
	logic [3:0] s_wstrb;
	logic [1:0] r;
	logic ep_q, rst_q;
	wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, dev_reset_n, flash_write_enable_pin, mem_wr, mem_rd;
	wire software_write_enable, erase_setup, erase_pulse, erase_verify, program_setup, program_pulse, program_verify;
	wire [1:0] s_bresp, s_rresp;
	wire [31:0] s_rdata;
	wire [15:0] mem_addr;
	wire [7:0] mem_wdata, mem_rdata;
	int errors, checked, ep_cnt, rst_cnt;
	logic [42:0] rows [13] = '{{1'h0, 8'h00, 32'h0, 2'h0}, {1'h0, 8'h04, 32'h0, 2'h0}, {1'h0, 8'h08, 32'h1, 2'h0},
		{1'h0, 8'h0C, 32'h0, 2'h0}, {1'h0, 8'h10, 32'h0, 2'h0}, {1'h0, 8'h14, 32'h0, 2'h2}, {1'h1, 8'h14, 32'h0, 2'h2},
		{1'h1, 8'h08, 32'h2, 2'h0}, {1'h0, 8'h08, 32'h2, 2'h0}, {1'h1, 8'h04, 32'h100, 2'h0},
		{1'h0, 8'h04, 32'h100, 2'h0}, {1'h1, 8'h00, 32'h3, 2'h0}, {1'h0, 8'h10, 32'h0, 2'h0}};
	fes_sequencer #(.ERASE_PULSE_CYC(32'h32), .ERASE_PULSE_MAX_CYC(32'h64), .PROG_LONG_CYC(32'h14)) dut (.*);
	fes_flash_model u_dev (.*);
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		ep_q <= erase_pulse;
		rst_q <= dev_reset_n;
		if (erase_pulse && !ep_q) ep_cnt++;
		if (!dev_reset_n && rst_q) rst_cnt++;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task give_up;
		errors++;
		final_report;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic aw, w;
		{aw, w, n} = '0;
		s_awaddr <= a;
		s_awvalid <= 1;
		s_wdata <= v;
		s_wvalid <= 1;
		s_bready <= 1;
		do begin
			@(posedge clock);
			if (s_awready && s_awvalid) begin aw = 1; s_awvalid <= 0; end
			if (s_wready && s_wvalid) begin w = 1; s_wvalid <= 0; end
			if (++n > 500) give_up;
		end while (!(aw && w && s_bvalid));
		rs = s_bresp;
		s_bready <= 0;
		@(posedge clock);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		logic ar;
		{ar, n} = '0;
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do begin
			@(posedge clock);
			if (s_arready && s_arvalid) begin ar = 1; s_arvalid <= 0; end
			if (++n > 500) give_up;
		end while (!(ar && s_rvalid));
		v = s_rdata;
		rs = s_rresp;
		s_rready <= 0;
		@(posedge clock);
	endtask
	task wait_stat(input int b, input logic val);
		int n;
		n = 0;
		do begin
			rd(8'h10, d, r);
			if (++n > 10000) give_up;
		end while (d[b] !== val);
	endtask
	initial begin
		{errors, checked, ep_cnt, rst_cnt} = '0;
		{arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
		{s_wstrb, watchdog_running, power_good, fail_first} = {4'hF, 2'h3, 8'h01};
		repeat (3) @(posedge clock);
		arst_n <= 1;
		@(posedge clock);
		chk({dev_reset_n, flash_write_enable_pin}, 32'h2);
		for (int i = 0; i < 13; i++) begin
			if (rows[i][42]) wr(rows[i][41:34], rows[i][33:2], r);
			else rd(rows[i][41:34], d, r);
			if (!rows[i][42] && r == 2'h0) chk(d, rows[i][33:2]);
			chk(r, rows[i][1:0]);
		end
		// Erase whose first pulse the device ignores, so one retry is due
		wr(8'h00, 32'h1, r);
		wait_stat(0, '0);
		chk(d & 32'hF, 32'h2);
		chk(ep_cnt, 32'h2);
		chk({u_dev.mem[16'h0100], u_dev.mem[16'h0101]}, 32'hFFFF);
		chk(flash_write_enable_pin, 32'h0);
		chk(rst_cnt, 32'h0);
		// Boot-mode program held back until the watchdog runs
		watchdog_running <= 0;
		fail_first <= 8'h00;
		wr(8'h0C, 32'h5A, r);
		wr(8'h04, 32'h200, r);
		wr(8'h00, 32'h6, r);
		wait_stat(3, '1);
		chk(program_pulse, 32'h0);
		watchdog_running <= 1;
		wait_stat(0, '0);
		chk(d & 32'hF, 32'h2);
		chk(rst_cnt, 32'h2);
		for (int i = 0; i < 128; i++) chk(u_dev.mem[16'h0200 + i], 32'h5A);
		chk(u_dev.mem[16'h0280], 32'hFF);
		// Power lost in mid-pulse
		wr(8'h00, 32'h1, r);
		for (int n = 0; !erase_pulse; n++) begin
			if (n > 20000) give_up;
			@(posedge clock);
		end
		power_good <= 0;
		repeat (6) @(posedge clock);
		chk({flash_write_enable_pin, software_write_enable, erase_setup, erase_pulse}, 32'h0);
		power_good <= 1;
		wait_stat(0, '0);
		chk(d & 32'hF, 32'h4);
		final_report;
	end
endmodule
